// [ulam_defines.vh]
`ifndef ULAM_DEFINES_VH
`define ULAM_DEFINES_VH

// Register byte addresses
`define ULAM_ADDR_FUNCTION_CONTROL_REG   5'h00
`define ULAM_ADDR_INTERFACE_CONTROL_REG   5'h04
`define ULAM_ADDR_STATUS      5'h08
`define ULAM_ADDR_IRQ_STAT    5'h0C
// Second register page (bit 4 of the address)
`define ULAM_ADDR_IRQ_CLR     5'h10
`define ULAM_ADDR_IRQ_EN      5'h14

// Function control fields
`define ULAM_FC_SUSPEND_BIT   0
`define ULAM_FC_RESET         32'h0000_0001

// Interface control fields
`define ULAM_IC_SIX_BIT       0
`define ULAM_IC_THREE_BIT     1
`define ULAM_IC_CLKRUN_BIT    3
`define ULAM_IC_RESET         32'h0000_0000

// Mode encodings
`define ULAM_MODE_SYNC        2'h0
`define ULAM_MODE_LOWPWR      2'h1
`define ULAM_MODE_SIX         2'h2
`define ULAM_MODE_THREE       2'h3

// Interrupt event bits
`define ULAM_EV_WIDTH         4
`define ULAM_EV_ENTER         0
`define ULAM_EV_EXIT          1
`define ULAM_EV_LINE          2
`define ULAM_EV_SRC           3

// Bus responses
`define ULAM_RESP_OKAY        2'h0
`define ULAM_RESP_SLVERR      2'h2

`endif

// [ulam_sync3.v]
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module ulam_sync3 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1_q[i]     <= 1'b0;
					s2_q[i]     <= 1'b0;
					s3_q[i]     <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						sync_out[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

endmodule

// [ulam_bus_map.v]
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ulam_defines.vh"
// What this block does
// RQ1: Bit 2 is driven low in low-power mode and bit 7 low in six-pin serial mode.
// RQ2: Bits 7 to 4 are driven low in low-power and three-pin serial modes.
// RQ3: In low-power and both serial modes bit 3 is a high-active flag of any unmasked interrupt.
// RQ4: The link enters six-pin serial mode by writing 1 to the six-pin select bit.
// RQ5: Asserting stop leaves six-pin serial mode and the bus returns to synchronous use.
// RQ6: The link enters three-pin serial mode by writing 1 to the three-pin select bit.
// RQ7: Asserting stop leaves three-pin serial mode and the synchronous bus is restored.
// RQ8: The output clock runs in serial modes only when the keep-running bit is 1.
// RQ9: In six-pin mode the link drives transmit enable, data and single-ended zero on bits 0-2.
// RQ10: In six-pin mode bits 4, 5 and 6 carry plus-line, minus-line and differential receive data.
// RQ11: In three-pin mode bit 1 is driven by the link while transmit enable is high, else by us.
// RQ12: In three-pin mode bit 2 is likewise shared for single-ended zero.
// RQ13: In low-power mode bits 0 and 1 carry the line state straight from the receiver.
// RQ14: Direction is held high for the whole of low-power and serial modes.
// RQ15: The link enters low-power mode by clearing the suspend bit and leaves by holding stop.
// RQ16: The link holds stop high until the bus is back in synchronous mode.
// RQ17: The link never sets both serial select bits at once.
module ulam_bus_map (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Link-side pins
	input  wire        stp,
	output reg         dir,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output reg  [7:0]  data_oe,
	output reg         clk_out_en,
	// Analog receiver and interrupt sources
	input  wire        line_state_bit0,
	input  wire        line_state_bit1,
	input  wire        rx_plus_line,
	input  wire        rx_minus_line,
	input  wire        rx_diff_line,
	input  wire        rx_single_zero,
	input  wire        int_source,
	input  wire        int_source_mask_n,
	// Transmit toward the analog driver
	output reg         tx_enable,
	output reg         tx_diff_line,
	output reg         tx_single_zero_line,
	// Interrupt to software
	output reg         irq
);

	reg [31:0] function_control_reg_q;
	reg [31:0] interface_control_reg_q;
	reg [1:0]  mode_q;
	reg [`ULAM_EV_WIDTH-1:0] irq_stat_q;
	reg [`ULAM_EV_WIDTH-1:0] irq_en_q;
	reg [1:0]  line_prev_q;

	// Pin inputs through three-stage synchronisers
	wire [12:0] pin_sync;
	ulam_sync3 #(
		.WIDTH (13)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({stp, data_in[2:0], line_state_bit1, line_state_bit0, rx_plus_line,
		            rx_minus_line, rx_diff_line, rx_single_zero, int_source,
		            int_source_mask_n, 1'b0}),
		.sync_out (pin_sync)
	);
	wire       stp_s    = pin_sync[12];
	wire [2:0] link_s   = pin_sync[11:9];
	wire [1:0] line_s   = pin_sync[8:7];
	wire       rxp_s    = pin_sync[6];
	wire       rxm_s    = pin_sync[5];
	wire       rxd_s    = pin_sync[4];
	wire       rxse0_s  = pin_sync[3];
	wire       int_src_s = pin_sync[2];
	wire       int_mk_s  = pin_sync[1];

	wire suspend_ctl_n      = function_control_reg_q[`ULAM_FC_SUSPEND_BIT];
	wire six_pin_serial_sel = interface_control_reg_q[`ULAM_IC_SIX_BIT];
	wire three_pin_serial_sel = interface_control_reg_q[`ULAM_IC_THREE_BIT];
	wire clock_keep_running = interface_control_reg_q[`ULAM_IC_CLKRUN_BIT];

	// Unmasked interrupt source shown on bit 3
	wire int_flag = int_src_s & int_mk_s;

	// Mode machine
	reg [1:0] mode_d;
	reg       leave;
	always @* begin
		mode_d = mode_q;
		leave  = 1'b0;
		case (mode_q)
			`ULAM_MODE_SYNC: begin
				if (!suspend_ctl_n)
					mode_d = `ULAM_MODE_LOWPWR;
				else if (six_pin_serial_sel)
					mode_d = `ULAM_MODE_SIX; // RQ4
				else if (three_pin_serial_sel)
					mode_d = `ULAM_MODE_THREE; // RQ6
			end
			`ULAM_MODE_LOWPWR, `ULAM_MODE_SIX, `ULAM_MODE_THREE: begin
				if (stp_s) begin
					mode_d = `ULAM_MODE_SYNC; // RQ5 RQ7
					leave  = 1'b1;
				end
			end
			default: mode_d = `ULAM_MODE_SYNC;
		endcase
	end

	// Pin mapping for the next cycle
	reg [7:0] dout_d;
	reg [7:0] doe_d;
	reg       tx_en_d;
	reg       tx_diff_line_d;
	reg       tx_single_zero_line_d;
	always @* begin
		dout_d   = 8'h00;
		doe_d    = 8'h00;
		tx_en_d  = 1'b0;
		tx_diff_line_d = 1'b0;
		tx_single_zero_line_d = 1'b0;
		case (mode_d)
			`ULAM_MODE_LOWPWR: begin
				doe_d     = 8'hFF;
				dout_d[1:0] = line_s; // RQ13
				dout_d[2] = 1'b0; // RQ1
				dout_d[3] = int_flag; // RQ3
				dout_d[7:4] = 4'h0; // RQ2
			end
			`ULAM_MODE_SIX: begin
				doe_d     = 8'hF8; // RQ9
				dout_d[3] = int_flag; // RQ3
				dout_d[4] = rxp_s; // RQ10
				dout_d[5] = rxm_s; // RQ10
				dout_d[6] = rxd_s; // RQ10
				dout_d[7] = 1'b0; // RQ1
				tx_en_d   = link_s[0];
				tx_diff_line_d  = link_s[1];
				tx_single_zero_line_d  = link_s[2];
			end
			`ULAM_MODE_THREE: begin
				tx_en_d   = link_s[0];
				doe_d     = {4'hF, 1'b1, {2{~link_s[0]}}, 1'b0}; // RQ11 RQ12
				dout_d[1] = rxd_s; // RQ11
				dout_d[2] = rxse0_s; // RQ12
				dout_d[3] = int_flag; // RQ3
				dout_d[7:4] = 4'h0; // RQ2
				tx_diff_line_d  = link_s[0] & link_s[1]; // RQ11
				tx_single_zero_line_d  = link_s[0] & link_s[2]; // RQ12
			end
			default: begin
				doe_d = 8'h00;
			end
		endcase
	end

	// Mode, pins and output clock enable; the select bits are cleared on exit in the write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_q              <= `ULAM_MODE_SYNC;
			dir                 <= 1'b0;
			data_out            <= 8'h00;
			data_oe             <= 8'h00;
			clk_out_en          <= 1'b1;
			tx_enable           <= 1'b0;
			tx_diff_line        <= 1'b0;
			tx_single_zero_line <= 1'b0;
		end else begin
			mode_q              <= mode_d;
			dir                 <= (mode_d != `ULAM_MODE_SYNC); // RQ14
			data_out            <= dout_d;
			data_oe             <= doe_d;
			tx_enable           <= tx_en_d;
			tx_diff_line        <= tx_diff_line_d;
			tx_single_zero_line <= tx_single_zero_line_d;
			if (mode_d == `ULAM_MODE_SIX || mode_d == `ULAM_MODE_THREE)
				clk_out_en <= clock_keep_running; // RQ8
			else
				clk_out_en <= (mode_d != `ULAM_MODE_LOWPWR);
		end
	end

	// AXI4-Lite write channel
	reg        aw_have_q;
	reg        w_have_q;
	reg [4:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	wire       wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
	reg  [31:0] wmask;
	integer b;
	always @* begin
		wmask = 32'h0000_0000;
		for (b = 0; b < 4; b = b + 1)
			wmask[b*8 +: 8] = {8{w_strb_q[b]}};
	end
	wire [31:0] wval_fc = (function_control_reg_q & ~wmask) | (w_data_q & wmask);
	wire [31:0] wval_ic = (interface_control_reg_q & ~wmask) | (w_data_q & wmask);

	// Interrupt events
	wire [`ULAM_EV_WIDTH-1:0] ev;
	assign ev[`ULAM_EV_ENTER] = (mode_q == `ULAM_MODE_SYNC) && (mode_d != `ULAM_MODE_SYNC);
	assign ev[`ULAM_EV_EXIT]  = leave;
	assign ev[`ULAM_EV_LINE]  = (line_s != line_prev_q);
	assign ev[`ULAM_EV_SRC]   = int_flag;
	wire wr_clr = wr_go && aw_addr_q == `ULAM_ADDR_IRQ_CLR && w_strb_q[0];
	wire [`ULAM_EV_WIDTH-1:0] clr_bits = wr_clr ? w_data_q[`ULAM_EV_WIDTH-1:0] : 4'h0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready           <= 1'b0;
			s_axi_wready            <= 1'b0;
			s_axi_bvalid            <= 1'b0;
			s_axi_bresp             <= `ULAM_RESP_OKAY;
			aw_have_q               <= 1'b0;
			w_have_q                <= 1'b0;
			aw_addr_q               <= 5'h00;
			w_data_q                <= 32'h0000_0000;
			w_strb_q                <= 4'h0;
			function_control_reg_q  <= `ULAM_FC_RESET;
			interface_control_reg_q <= `ULAM_IC_RESET;
			irq_en_q                <= 4'h0;
			irq_stat_q              <= 4'h0;
			line_prev_q             <= 2'h0;
			irq                     <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `ULAM_RESP_OKAY;
				case (aw_addr_q)
					`ULAM_ADDR_FUNCTION_CONTROL_REG: function_control_reg_q <= wval_fc;
					`ULAM_ADDR_INTERFACE_CONTROL_REG: interface_control_reg_q <= wval_ic;
					`ULAM_ADDR_IRQ_CLR: ;
					`ULAM_ADDR_IRQ_EN: if (w_strb_q[0]) irq_en_q <= w_data_q[3:0];
					default: s_axi_bresp <= `ULAM_RESP_SLVERR;
				endcase
			end
			// Leaving by stop wakes the device and drops the select bits
			if (leave) begin
				function_control_reg_q[`ULAM_FC_SUSPEND_BIT] <= 1'b1; // RQ5 RQ7
				interface_control_reg_q[`ULAM_IC_SIX_BIT]    <= 1'b0;
				interface_control_reg_q[`ULAM_IC_THREE_BIT]  <= 1'b0;
			end
			line_prev_q <= line_s;
			// Set wins over clear
			irq_stat_q  <= (irq_stat_q & ~clr_bits) | ev;
			irq         <= |(((irq_stat_q & ~clr_bits) | ev) & irq_en_q);
		end
	end

	// AXI4-Lite read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ULAM_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `ULAM_RESP_OKAY;
				case (s_axi_araddr)
					`ULAM_ADDR_FUNCTION_CONTROL_REG: s_axi_rdata <= function_control_reg_q;
					`ULAM_ADDR_INTERFACE_CONTROL_REG: s_axi_rdata <= interface_control_reg_q;
					`ULAM_ADDR_STATUS:
						s_axi_rdata <= {28'h0000000, dir, 1'b0, mode_q};
					`ULAM_ADDR_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_q};
					`ULAM_ADDR_IRQ_CLR: s_axi_rdata <= 32'h0000_0000;
					`ULAM_ADDR_IRQ_EN: s_axi_rdata <= {28'h0000000, irq_en_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `ULAM_RESP_SLVERR;
					end
				endcase
			end
		end
	end

endmodule

// [ulam_bus_map_sva.sv]
`timescale 1ns/1ns
module ulam_bus_map_sva (
	// Clock and reset
	input wire       aclk,
	input wire       aresetn,
	// Link-side pins
	input wire       stp,
	input wire       dir,
	input wire [7:0] data_out,
	input wire [7:0] data_oe,
	// Interrupt source
	input wire       int_source,
	input wire       int_source_mask_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire       int_lvl = int_source & int_source_mask_n;
	reg        int_prev_q;
	reg  [3:0] int_age_q;
	// Age of the unmasked interrupt level, so the flag is judged only once synchronised
	always @(posedge aclk) begin
		int_prev_q <= int_lvl;
		if (!aresetn || int_lvl != int_prev_q)
			int_age_q <= 4'h0;
		else if (int_age_q != 4'hF)
			int_age_q <= int_age_q + 4'h1;
	end
	chk_dir_drive: assert property (dir |-> data_oe[7:3] == 5'h1F)
		else $error("dir high without upper bus drive");
	chk_sync_release: assert property (!dir |-> data_oe == 8'h00)
		else $error("bus driven in synchronous mode");
	chk_top_low: assert property (dir |-> !data_out[7])
		else $error("bit 7 not low");
	chk_lp_reserved: assert property (dir && data_oe == 8'hFF |-> data_out[7:4] == 4'h0 && !data_out[2])
		else $error("low-power reserved bits not low");
	chk_three_reserved: assert property (dir && data_oe == 8'hFE |-> data_out[7:4] == 4'h0)
		else $error("three-pin reserved bits not low");
	chk_bidir_pair: assert property (data_oe[1] == data_oe[2])
		else $error("shared bits turned apart");
	chk_int_flag: assert property (dir && int_age_q >= 4'h8 |-> data_out[3] == int_prev_q)
		else $error("interrupt flag wrong");
	chk_stop_exit: assert property (stp [*8] |-> ##[0:4] !dir)
		else $error("stop did not release bus");
	chk_dir_hold: assert property ((!stp) [*7] ##0 dir |=> dir)
		else $error("dir dropped without stop");
	cover property (dir && data_oe == 8'hFF);
	cover property (dir && data_oe == 8'hF8 && data_out[6:4] != 3'h0);
	cover property (dir && data_oe == 8'hFE);
endmodule

bind ulam_bus_map ulam_bus_map_sva chk (.aclk(aclk), .aresetn(aresetn), .stp(stp), .dir(dir),
	.data_out(data_out), .data_oe(data_oe), .int_source(int_source),
	.int_source_mask_n(int_source_mask_n));

// [ulam_link_model.sv]
`timescale 1ns/1ns
module ulam_link_model (
	// Clock
	input wire       aclk,
	// Bus from the block
	input wire       dir,
	input wire [7:0] data_out,
	input wire [7:0] data_oe,
	// Bus toward the block
	output reg       stp,
	output wire [7:0] data_in
);
	reg        three_q = 1'b0;
	reg  [2:0] tx_q = 3'h0;
	reg  [7:0] last_q = 8'h00;
	// Link owns bits 0-2 in serial modes; in three-pin only bit 0 while transmit is off
	wire [7:0] lnk_oe = !dir ? 8'hFF : {5'h00, {2{~three_q | tx_q[0]}}, 1'b1};
	wire [7:0] lnk_v  = dir ? {5'h00, tx_q} : 8'h00;
	// Undriven bits show the inverse of their last level
	assign data_in = (data_oe & data_out) | (~data_oe & lnk_oe & lnk_v) | (~data_oe & ~lnk_oe & ~last_q);
	always @(posedge aclk)
		last_q <= ((data_oe | lnk_oe) & data_in) | (~(data_oe | lnk_oe) & last_q);
	initial
		stp = 1'b0;
	task drive(input bit three, input [2:0] v);
		three_q <= three;
		tx_q <= v;
	endtask
	// Stop is held until the block releases the bus
	task stop;
		int n;
		n = 0;
		stp <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (dir !== 1'b0 && n < 30);
		@(posedge aclk);
		stp <= 1'b0;
		tx_q <= 3'h0;
	endtask
endmodule

// [ulam_bus_map_tb_top.sv]
`timescale 1ns/1ns
`include "ulam_defines.vh"
module ulam_bus_map_tb_top;
	logic        aclk, aresetn, stp, dir, clk_out_en, irq;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  data_in, data_out, data_oe;
	logic        line_state_bit0, line_state_bit1, rx_plus_line, rx_minus_line, rx_diff_line;
	logic        rx_single_zero, int_source, int_source_mask_n;
	logic        tx_enable, tx_diff_line, tx_single_zero_line;
	int          fails, checks_done;
	ulam_bus_map dut (.*);
	ulam_link_model link (.aclk(aclk), .dir(dir), .data_out(data_out), .data_oe(data_oe),
		.stp(stp), .data_in(data_in));
	task automatic chk(input string s, input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input bit wr, input [4:0] a, input [31:0] d, output [31:0] rd,
		output [1:0] rs);
		bit ha, hw, hb, da, dw;
		da = 0;
		dw = !wr;
		hb = 0;
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		while (!hb) begin
			@(negedge aclk);
			ha = wr ? s_axi_awready : s_axi_arready;
			hw = s_axi_wready;
			hb = wr ? s_axi_bvalid : s_axi_rvalid;
			rd = s_axi_rdata;
			rs = wr ? s_axi_bresp : s_axi_rresp;
			// An answer must follow the taking of every request channel
			if (hb)
				chk("bus order", 1, da & dw);
			da = da | ha;
			dw = dw | hw;
			@(posedge aclk);
			if (ha)
				{s_axi_awvalid, s_axi_arvalid} <= 2'h0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			if (hb)
				{s_axi_bready, s_axi_rready} <= 2'h0;
		end
		// Let an edge pass so the next call does not reassign a released ready
		@(posedge aclk);
	endtask
	// Analog receiver and interrupt source levels in one word
	task automatic rx(input [7:0] v);
		{int_source_mask_n, int_source, rx_single_zero, rx_diff_line, rx_minus_line,
			rx_plus_line, line_state_bit1, line_state_bit0} <= v;
	endtask
	task automatic settle;
		repeat (8) @(posedge aclk);
	endtask
	task automatic t_regs;
		bus(0, `ULAM_ADDR_FUNCTION_CONTROL_REG, 0, q, r);
		chk("fc reset", 32'h0000_0001, q);
		bus(0, `ULAM_ADDR_INTERFACE_CONTROL_REG, 0, q, r);
		chk("ic reset", 32'h0000_0000, q);
		bus(0, 5'h18, 0, q, r);
		chk("unmapped rd", {30'h0, `ULAM_RESP_SLVERR}, {q[29:0], r});
		bus(1, 5'h1C, 32'hFFFF_FFFF, q, r);
		chk("unmapped wr", `ULAM_RESP_SLVERR, r);
		chk("sync clk", 1, clk_out_en);
	endtask
	task automatic t_lowpower;
		rx(8'hC2);
		bus(1, `ULAM_ADDR_FUNCTION_CONTROL_REG, 0, q, r);
		settle;
		chk("lp dir", 8'hFF, {dir, data_oe[6:0]});
		chk("lp bus", 8'h0A, data_out);
		rx(8'h41);
		settle;
		chk("lp masked", 8'h01, data_out);
		link.stop;
		chk("lp exit", 0, {dir, data_oe});
	endtask
	task automatic t_six;
		rx(8'h94);
		link.drive(1'b0, 3'h5);
		bus(1, `ULAM_ADDR_INTERFACE_CONTROL_REG, 32'h0000_0009, q, r);
		settle;
		chk("six oe", 8'hF8, data_oe);
		chk("six bus", 5'h0A, data_out[7:3]);
		chk("six clk", 1, clk_out_en);
		chk("six tx", 3'h5, {tx_single_zero_line, tx_diff_line, tx_enable});
		bus(0, `ULAM_ADDR_STATUS, 0, q, r);
		chk("six status", 32'h0000_000A, q);
		link.stop;
		bus(0, `ULAM_ADDR_INTERFACE_CONTROL_REG, 0, q, r);
		chk("six exit", 32'h0000_0008, q);
	endtask
	task automatic t_three;
		rx(8'h90);
		link.drive(1'b1, 3'h0);
		bus(1, `ULAM_ADDR_INTERFACE_CONTROL_REG, 32'h0000_0002, q, r);
		settle;
		chk("three clk", 0, clk_out_en);
		chk("three rx", 15'h7F01, {data_oe, data_out[7:1]});
		link.drive(1'b1, 3'h7);
		// Turnaround of bits 1 and 2 needs two synchroniser passes
		settle;
		settle;
		chk("three tx", 11'h7C7, {data_oe, tx_single_zero_line, tx_diff_line, tx_enable});
		link.stop;
		chk("three exit", 0, dir);
	endtask
	task automatic t_irq;
		rx(8'h00);
		// Entry, exit, line change and source were all seen by the earlier scenarios
		bus(0, `ULAM_ADDR_IRQ_STAT, 0, q, r);
		chk("irq events", 4'hF, q[3:0]);
		bus(1, `ULAM_ADDR_IRQ_CLR, 32'h0000_000F, q, r);
		bus(1, `ULAM_ADDR_IRQ_EN, 32'h0000_0008, q, r);
		settle;
		chk("irq idle", 0, irq);
		rx(8'hC0);
		settle;
		chk("irq set", 1, irq);
		bus(0, `ULAM_ADDR_IRQ_STAT, 0, q, r);
		chk("irq stat", 1, q[3]);
		rx(8'h80);
		bus(1, `ULAM_ADDR_IRQ_EN, 0, q, r);
		settle;
		chk("irq masked", 0, irq);
		bus(1, `ULAM_ADDR_IRQ_CLR, 32'h0000_0008, q, r);
		bus(0, `ULAM_ADDR_IRQ_STAT, 0, q, r);
		chk("irq cleared", 0, q[3]);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
		s_axi_wstrb = 4'hF;
		rx(8'h80);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_lowpower;
		t_six;
		t_three;
		t_irq;
		wrap_up;
	end
endmodule
